/* rtl/fhr_pkg.sv */
package fhr_pkg;
  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_STATUS_B   = 4'h1;
  localparam logic [3:0] IDX_DRIVE_OUT  = 4'h2;
  localparam logic [3:0] IDX_TAPE       = 4'h3;
  localparam logic [3:0] IDX_MAIN_RATE  = 4'h4;
  localparam logic [3:0] IDX_DATA       = 4'h5;
  localparam logic [3:0] IDX_DIAG_CC    = 4'h7;
  localparam logic [3:0] IDX_MODE_CFG   = 4'h8;
  localparam logic [3:0] IDX_CFG_SEVEN  = 4'h9;
  localparam logic [3:0] IDX_CFG_EIGHT  = 4'hA;

  // mode/config register fields
  localparam int CFG_MODE_LSB  = 0;
  localparam int CFG_3MODE_BIT = 2;
  localparam int CFG_EXTR_LSB  = 3;

  localparam logic [7:0] CONFIGURE_CMD = 8'h13;
  localparam int         EFIFO_BIT     = 5;
  localparam int         STACK_DEPTH   = 4;

  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [1:0] RATE_1M   = 2'h3;
  localparam logic [1:0] EXT_RATE_TAPE = 2'h2;

  // precompensation in steps of the base step
  localparam logic [2:0] SELECT_A_DEFAULT = 3'h0;
  localparam logic [2:0] SELECT_A_OFF     = 3'h7;
  localparam logic [2:0] DEF_STEPS_LOW   = 3'h3;
  localparam logic [2:0] DEF_STEPS_1M    = 3'h1;

  localparam logic [7:0] DRIVE_OUT_RST = 8'h00;
  localparam logic [7:0] RATE_CTL_RST  = 8'h00;
  localparam logic [7:0] MODE_CFG_RST  = 8'h01;

  typedef enum logic [1:0] {FHR_BASIC, FHR_STANDARD, FHR_ALTERNATE} fhr_mode_t;

  typedef struct packed {
    logic [3:0] motor_on;
    logic       dma_en;
    logic       ctl_run;
    logic [1:0] drive_sel;
  } fhr_dor_t;

  typedef struct packed {
    logic       sw_reset;
    logic       power_down;
    logic       unused5;
    logic [2:0] select_a;
    logic [1:0] rate;
  } fhr_drr_t;
endpackage

/* rtl/fhr_regs.sv */
// Function
// [R1] standard mode: status B bit 5 reads drive select bit 0.
// [R2] standard mode: status B bit 4 toggles on write data rising edge.
// [R3] standard mode: status B bit 3 toggles on read data rising edge.
// [R4] status B bits 2..1 show inverted write enable and motor B pins, bit 0 inverted motor A outside alternate mode.
// [R5] alternate mode: status B bit 0 is low when drive C selected.
// [R6] drive output register is write-only and cleared by master reset.
// [R7] three-mode off: tape register holds only its two low bits.
// [R8] three-mode on: tape register shows media, drive type, boot fields.
// [R9] extended tape bits 7:6 are config eight bits 3:2, read-only.
// [R10] extended tape bits 5:4 are config seven pair of last selected drive.
// [R11] extended tape bits 3:2 are config eight bits 1:0.
// [R12] tape select 00 none, 01..11 drives 1..3; drive 0 never tape.
// [R13] effective rate comes from last write of rate or config control.
// [R14] rate register bit 7 software reset, bit 6 power-down.
// [R15] rate bits 4:2 pick select_a: 000 default, 001-110 steps, 111 off.
// [R16] rate bits 1:0 select data rate and reduced write current.
// [R17] 2M tape rate only with rate 01 and extended rate 10.
// [R18] data register leaves reset with fifo disabled; configure enables it.
// [R19] data register is a stack of four status bytes, one shown at a time.
// [R20] basic mode: diagnostic read drives only bit 7, inverted change.
// [R21] standard mode: diag bit7 ~change, 6:3 ones, 2:1 rate, 0 density.
// [R22] alternate mode: diag bit7 change, 6:4 ones, dma, no-select_a flag, rate.
// [R23] reserved control bits written as zero; alternate keeps bit 2 flag.
// [R24] diagnostic rate field equals the effective rate last written.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module fhr_regs
  import fhr_pkg::*;
(
  input  wire logic        pclk,                  // bus clock
  input  wire logic        presetn,               // master reset, active low
  input  wire logic        psel,                  // apb select
  input  wire logic        penable,               // apb enable
  input  wire logic        pwrite,                // apb direction
  input  wire logic [5:0]  paddr,                 // apb byte address
  input  wire logic [31:0] pwdata,                // apb write data
  output logic      [31:0] prdata,                // apb read data
  output logic             pready,                // apb ready
  output logic             pslverr,               // apb error
  input  wire logic        write_data_out_n,      // write data pin
  input  wire logic        read_data_n,           // read data pin
  input  wire logic        write_enable_n,        // write enable pin
  input  wire logic        media_changed_n,       // disk change pin
  input  wire logic [7:0]  main_status,           // core flow status
  input  wire logic        result_load,           // core loads status stack
  input  wire logic [31:0] result_stack,          // four status bytes
  output logic             motor_a_on_n,          // motor a pin
  output logic             motor_b_on_n,          // motor b pin
  output logic             drive_c_selected_n,    // drive c select flag
  output logic [1:0]       drive_sel,             // selected drive
  output logic             transfer_request_enable, // dma/irq enable
  output logic             controller_reset,      // core reset level
  output logic             sw_reset_pulse,        // soft reset strobe
  output logic             power_down,            // core power-down
  output logic [1:0]       rate_sel,              // effective rate
  output logic             reduced_write_current, // reduced write current level
  output logic             tape_rate_2m,          // 2 mbps tape rate
  output logic [2:0]       select_a_steps,         // select_a delay steps
  output logic             select_a_half_step,     // steps are half size
  output logic [1:0]       tape_drive,            // tape logical drive
  output logic             fifo_enable,           // data fifo enabled
  output logic [7:0]       cmd_byte,              // last command byte
  output logic             cmd_strobe             // command byte written
);

  fhr_dor_t   dor_ff;
  fhr_drr_t   drr_ff;
  logic [1:0] rate_ff;
  logic       no_select_a_flag_ff;
  logic [1:0] tape_ff;
  logic [7:0] cfg_ff;
  logic [7:0] cfg_seven_ff;
  logic [3:0] cfg_eight_ff;
  logic       wtog_ff;
  logic       rtog_ff;
  logic       wdat_prev_ff;
  logic       rd_prev_ff;
  logic       fifo_en_ff;
  logic [1:0] cfg_seq_ff;
  logic [1:0] ptr_ff;
  logic [7:0] stack_ff [STACK_DEPTH];
  logic [31:0] prdata_ff;
  logic [7:0] cmd_ff;
  logic       cmd_stb_ff;
  logic       swr_ff;

  // bus decode
  wire [3:0]  idx       = paddr[5:2];
  wire        setup     = psel & ~penable;
  wire        access    = psel & penable;
  wire        wr_en     = access & pwrite;
  wire        rd_acc    = access & ~pwrite;
  wire        mapped    = (paddr[1:0] == 2'h0) &
                          ((pwrite & (idx == IDX_DRIVE_OUT || idx == IDX_TAPE ||
                                      idx == IDX_MAIN_RATE || idx == IDX_DATA ||
                                      idx == IDX_DIAG_CC || idx == IDX_MODE_CFG ||
                                      idx == IDX_CFG_SEVEN || idx == IDX_CFG_EIGHT)) |
                           (~pwrite & (idx == IDX_STATUS_B || idx == IDX_TAPE ||
                                       idx == IDX_MAIN_RATE || idx == IDX_DATA ||
                                       idx == IDX_DIAG_CC || idx == IDX_MODE_CFG ||
                                       idx == IDX_CFG_SEVEN || idx == IDX_CFG_EIGHT)));
  wire        wr_ok     = wr_en & mapped;
  wire        wr_dor    = wr_ok & (idx == IDX_DRIVE_OUT);
  wire        wr_tape   = wr_ok & (idx == IDX_TAPE);
  wire        wr_drr    = wr_ok & (idx == IDX_MAIN_RATE);
  wire        wr_data   = wr_ok & (idx == IDX_DATA);
  wire        wr_cc     = wr_ok & (idx == IDX_DIAG_CC);
  wire        wr_cfg    = wr_ok & (idx == IDX_MODE_CFG);
  wire        wr_seven  = wr_ok & (idx == IDX_CFG_SEVEN);
  wire        wr_eight  = wr_ok & (idx == IDX_CFG_EIGHT);
  wire        rd_data   = rd_acc & mapped & (idx == IDX_DATA);
  wire [7:0]  wbyte     = pwdata[7:0];

  // configuration fields
  wire fhr_mode_t mode      = fhr_mode_t'(cfg_ff[CFG_MODE_LSB +: 2]);
  wire        three_mode_enable = cfg_ff[CFG_3MODE_BIT];
  wire [1:0]  ext_rate      = cfg_ff[CFG_EXTR_LSB +: 2];
  wire        is_alt        = (mode == FHR_ALTERNATE);
  wire        is_basic      = (mode == FHR_BASIC);

  // pin edges
  wire        wdat_rise = write_data_out_n & ~wdat_prev_ff;
  wire        rd_rise   = read_data_n & ~rd_prev_ff;

  // status register b
  wire [7:0]  sb_std    = {2'b11, dor_ff.drive_sel[0], wtog_ff, rtog_ff,     // [R1] [R2] [R3]
                           ~write_enable_n, ~motor_b_on_n, ~motor_a_on_n};   // [R4]
  wire [7:0]  sb_val    = is_alt ? {sb_std[7:1], drive_c_selected_n} : sb_std; // [R5]

  // tape drive register
  wire [1:0]  type_pair = cfg_seven_ff[{dor_ff.drive_sel, 1'b0} +: 2];        // [R10]
  wire [7:0]  td_ext    = {cfg_eight_ff[3:2], type_pair, cfg_eight_ff[1:0], tape_ff}; // [R8] [R9] [R11]
  wire [7:0]  td_val    = three_mode_enable ? td_ext : {6'h00, tape_ff};      // [R7]

  // diagnostic input register
  wire        high_density_n = (rate_ff == RATE_300K) | (rate_ff == RATE_250K);
  wire [7:0]  di_basic  = {~media_changed_n, 7'h00};                          // [R20]
  wire [7:0]  di_std    = {~media_changed_n, 4'hF, rate_ff, high_density_n};  // [R21] [R24]
  wire [7:0]  di_alt    = {media_changed_n, 3'h7, dor_ff.dma_en, no_select_a_flag_ff, rate_ff}; // [R22]
  wire [7:0]  di_val    = is_basic ? di_basic : (is_alt ? di_alt : di_std);

  wire [7:0]  rd_byte   = (idx == IDX_STATUS_B)  ? sb_val :
                          (idx == IDX_TAPE)      ? td_val :
                          (idx == IDX_MAIN_RATE) ? main_status :
                          (idx == IDX_DATA)      ? stack_ff[ptr_ff] :         // [R19]
                          (idx == IDX_DIAG_CC)   ? di_val :
                          (idx == IDX_MODE_CFG)  ? cfg_ff :
                          (idx == IDX_CFG_SEVEN) ? cfg_seven_ff :
                          {4'h0, cfg_eight_ff};
  wire [31:0] nxt_prdata = (setup & ~pwrite & mapped) ? {24'h000000, rd_byte} : prdata_ff;

  // precompensation selection
  wire [2:0]  def_steps = (rate_ff == RATE_1M || tape_rate_2m) ? DEF_STEPS_1M : DEF_STEPS_LOW; // [R15]
  wire [2:0]  pc        = drr_ff.select_a;

  // configure command tracking: opcode, zero byte, then fifo byte
  wire        cfg_third = wr_data & (cfg_seq_ff == 2'h2);

  assign prdata      = prdata_ff;
  assign pready      = 1'b1;
  assign pslverr     = access & ~mapped;
  assign motor_a_on_n = ~dor_ff.motor_on[0];
  assign motor_b_on_n = ~dor_ff.motor_on[1];
  assign drive_c_selected_n = ~(dor_ff.drive_sel == 2'h2);
  assign drive_sel   = dor_ff.drive_sel;
  assign transfer_request_enable = dor_ff.dma_en;
  assign controller_reset = ~dor_ff.ctl_run;
  assign sw_reset_pulse = swr_ff;                                              // [R14]
  assign power_down  = drr_ff.power_down;                                      // [R14]
  assign rate_sel    = rate_ff;
  assign reduced_write_current = (rate_ff == RATE_500K) | (rate_ff == RATE_1M); // [R16]
  assign tape_rate_2m = (rate_ff == RATE_300K) & (ext_rate == EXT_RATE_TAPE);   // [R17]
  assign select_a_steps = (pc == SELECT_A_OFF) ? 3'h0 :                         // [R15]
                         (pc == SELECT_A_DEFAULT) ? def_steps : pc;
  assign select_a_half_step = tape_rate_2m;
  assign tape_drive  = tape_ff;                                                // [R12]
  assign fifo_enable = fifo_en_ff;
  assign cmd_byte    = cmd_ff;
  assign cmd_strobe  = cmd_stb_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dor_ff <= fhr_dor_t'(DRIVE_OUT_RST);                                     // [R6]
    end else if (wr_dor) begin
      dor_ff <= fhr_dor_t'(wbyte);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drr_ff    <= fhr_drr_t'(RATE_CTL_RST);
      rate_ff   <= RATE_500K;
      no_select_a_flag_ff <= 1'b0;
      swr_ff    <= 1'b0;
    end else begin
      swr_ff <= wr_drr & wbyte[7];                                             // [R14]
      if (wr_drr) begin
        drr_ff  <= fhr_drr_t'({1'b0, wbyte[6:0]});
        rate_ff <= wbyte[1:0];                                                 // [R13]
      end else if (wr_cc) begin
        rate_ff <= wbyte[1:0];                                                 // [R13]
      end
      if (wr_cc && is_alt) begin
        no_select_a_flag_ff <= wbyte[2];                                        // [R23]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tape_ff <= 2'h0;
      cfg_ff  <= MODE_CFG_RST;
      cfg_seven_ff <= 8'h00;
      cfg_eight_ff <= 4'h0;
    end else begin
      if (wr_tape) tape_ff <= wbyte[1:0];
      if (wr_cfg) cfg_ff <= wbyte;
      if (wr_seven) cfg_seven_ff <= wbyte;
      if (wr_eight) cfg_eight_ff <= wbyte[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdat_prev_ff <= 1'b1;
      rd_prev_ff <= 1'b1;
      wtog_ff    <= 1'b0;
      rtog_ff    <= 1'b0;
    end else begin
      wdat_prev_ff <= write_data_out_n;
      rd_prev_ff <= read_data_n;
      wtog_ff    <= wtog_ff ^ wdat_rise;                                       // [R2]
      rtog_ff    <= rtog_ff ^ rd_rise;                                         // [R3]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_en_ff <= 1'b0;                                                      // [R18]
      cfg_seq_ff <= 2'h0;
      cmd_ff     <= 8'h00;
      cmd_stb_ff <= 1'b0;
    end else begin
      cmd_stb_ff <= wr_data;
      if (wr_data) cmd_ff <= wbyte;
      if (cfg_third) fifo_en_ff <= ~wbyte[EFIFO_BIT];                          // [R18]
      if (wr_data) begin
        if (cfg_seq_ff == 2'h0) cfg_seq_ff <= (wbyte == CONFIGURE_CMD) ? 2'h1 : 2'h0;
        else if (cfg_seq_ff == 2'h1) cfg_seq_ff <= 2'h2;
        else cfg_seq_ff <= 2'h0;
      end
    end
  end

  // status stack: load replaces all four, reads step through them
  genvar g;
  generate
    for (g = 0; g < STACK_DEPTH; g++) begin : g_stack
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stack_ff[g] <= 8'h00;
        end else if (result_load) begin
          stack_ff[g] <= result_stack[8*g +: 8];                               // [R19]
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_ff    <= 2'h0;
      prdata_ff <= 32'h00000000;
    end else begin
      prdata_ff <= nxt_prdata;
      if (result_load) ptr_ff <= 2'h0;
      else if (rd_data) ptr_ff <= ptr_ff + 2'h1;                               // [R19]
    end
  end

  chk_sb_drive_sel: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    (setup && !pwrite && paddr == 6'h04 && mode == FHR_STANDARD)
      |=> prdata[5] == $past(dor_ff.drive_sel[0]))
    else $error("status b bit 5 not drive select 0");

  chk_wdata_toggle: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    $rose(write_data_out_n) |=> wtog_ff != $past(wtog_ff))
    else $error("write data toggle missed");

  chk_rdata_toggle: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    (!$rose(read_data_n)) |=> rtog_ff == $past(rtog_ff))
    else $error("read data toggle without edge");

  chk_rdata_edge: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    $rose(read_data_n) |=> rtog_ff != $past(rtog_ff))
    else $error("read data edge did not toggle");

  chk_wdata_quiet: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    (!$rose(write_data_out_n)) |=> wtog_ff == $past(wtog_ff))
    else $error("write data toggle without edge");

  chk_tape_narrow: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
    !three_mode_enable |-> td_val[7:2] == 6'h00)
    else $error("tape register upper bits set in normal mode");

  chk_rate_last: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
    (wr_drr || wr_cc) |=> rate_ff == $past(wbyte[1:0]) ##1 (rate_ff == $past(rate_ff) || wr_drr || wr_cc))
    else $error("rate not taken from last write");

  chk_pdown_write: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
    wr_drr |=> power_down == $past(wbyte[6]) && sw_reset_pulse == $past(wbyte[7]))
    else $error("power-down or soft reset wrong");

  chk_tape_rate: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
    tape_rate_2m |-> rate_ff == RATE_300K && ext_rate == EXT_RATE_TAPE)
    else $error("2M tape rate without its settings");

  chk_fifo_cfg: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
    (!cfg_third && $past(presetn)) |=> fifo_en_ff == $past(fifo_en_ff))
    else $error("fifo enable changed outside configure");

  chk_diag_alt: assert property (@(posedge pclk) disable iff (!presetn) // [R22]
    (setup && !pwrite && paddr == 6'h1C && is_alt)
      |=> prdata[7:0] == {$past(media_changed_n), 3'h7, $past(dor_ff.dma_en),
                          $past(no_select_a_flag_ff), $past(rate_ff)})
    else $error("alternate diagnostic layout wrong");

  chk_sb_drive_c: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    (setup && !pwrite && paddr == 6'h04 && is_alt)
      |=> prdata[0] == ($past(dor_ff.drive_sel) != 2'h2))
    else $error("alternate status b drive c flag wrong");

  chk_sb_pins: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    (setup && !pwrite && paddr == 6'h04)
      |=> prdata[2] == !$past(write_enable_n) && prdata[1] == !$past(motor_b_on_n))
    else $error("status b pin bits wrong");

  chk_dor_write: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    wr_dor |=> drive_sel == $past(wbyte[1:0]) && transfer_request_enable == $past(wbyte[3]))
    else $error("drive output write not held");

  chk_tape_media: assert property (@(posedge pclk) disable iff (!presetn) // [R9] [R11]
    (setup && !pwrite && paddr == 6'h0C && three_mode_enable)
      |=> prdata[7:6] == $past(cfg_eight_ff[3:2]) && prdata[3:2] == $past(cfg_eight_ff[1:0]))
    else $error("tape media or boot field wrong");

  chk_write_current: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
    wr_drr |=> reduced_write_current == ($past(wbyte[1]) ~^ $past(wbyte[0])))
    else $error("reduced write current wrong for rate");

  chk_select_a_off: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
    (wr_drr && wbyte[4:2] == SELECT_A_OFF) |=> select_a_steps == 3'h0)
    else $error("precompensation not disabled");

  chk_stack_step: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
    (rd_data && !result_load) |=> ptr_ff == $past(ptr_ff) + 2'h1)
    else $error("status stack did not step");

  chk_diag_std: assert property (@(posedge pclk) disable iff (!presetn) // [R21]
    (setup && !pwrite && paddr == 6'h1C && mode == FHR_STANDARD)
      |=> prdata[7] == !$past(media_changed_n) && prdata[6:3] == 4'hF)
    else $error("standard diagnostic layout wrong");

  chk_diag_basic: assert property (@(posedge pclk) disable iff (!presetn) // [R20]
    (setup && !pwrite && paddr == 6'h1C && is_basic) |=> prdata[6:0] == 7'h00)
    else $error("basic diagnostic low bits not zero");

  chk_select_a_flag: assert property (@(posedge pclk) disable iff (!presetn) // [R23]
    (wr_cc && !is_alt) |=> no_select_a_flag_ff == $past(no_select_a_flag_ff))
    else $error("select_a flag stored outside alternate mode");

endmodule // fhr_regs

/* testbench/fhr_drive_model.sv */
`timescale 1ns/1ps
module fhr_drive_model (
  input  wire logic pclk,             // bus clock
  output logic      write_data_out_n, // write data pin
  output logic      read_data_n,      // read data pin
  output logic      write_enable_n,   // write enable pin
  output logic      media_changed_n   // disk change pin
);
  initial begin
    write_data_out_n = 1'b1;
    read_data_n      = 1'b1;
    write_enable_n   = 1'b1;
    media_changed_n  = 1'b1;
  end
  // data pins idle high; each pulse is two cycles low then high again
  task automatic pulse(input logic wr_pin, input int n);
    repeat (n) begin
      @(posedge pclk);
      if (wr_pin) write_data_out_n <= 1'b0;
      else read_data_n <= 1'b0;
      repeat (2) @(posedge pclk);
      if (wr_pin) write_data_out_n <= 1'b1;
      else read_data_n <= 1'b1;
      repeat (2) @(posedge pclk);
    end
  endtask
  task automatic set_lines(input logic we_n, input logic mc_n);
    @(posedge pclk);
    write_enable_n  <= we_n;
    media_changed_n <= mc_n;
    @(posedge pclk);
  endtask
endmodule // fhr_drive_model

/* testbench/fhr_regs_tb.sv */
`timescale 1ns/1ps
module fhr_regs_tb;
  import fhr_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [5:0]  paddr = 6'h00;
  logic [31:0] pwdata = 32'h0, prdata, result_stack = 32'h44332211;
  logic [7:0]  main_status = 8'h5A, cmd_byte, q;
  logic        result_load = 1'b0, pready, pslverr, e;
  logic        write_data_out_n, read_data_n, write_enable_n, media_changed_n;
  logic        motor_a_on_n, motor_b_on_n, drive_c_selected_n, transfer_request_enable;
  logic        controller_reset, sw_reset_pulse, power_down, reduced_write_current;
  logic        tape_rate_2m, select_a_half_step, fifo_enable, cmd_strobe;
  logic [1:0]  drive_sel, rate_sel, tape_drive;
  logic [2:0]  select_a_steps, ps;
  int          failures = 0, checks_done = 0, cyc = 0, swr = 0;

  fhr_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .write_data_out_n, .read_data_n, .write_enable_n, .media_changed_n, .main_status,
    .result_load, .result_stack, .motor_a_on_n, .motor_b_on_n, .drive_c_selected_n, .drive_sel,
    .transfer_request_enable, .controller_reset, .sw_reset_pulse, .power_down, .rate_sel,
    .reduced_write_current, .tape_rate_2m, .select_a_steps, .select_a_half_step, .tape_drive,
    .fifo_enable, .cmd_byte, .cmd_strobe);
  fhr_drive_model drv (.pclk, .write_data_out_n, .read_data_n, .write_enable_n, .media_changed_n);

  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (sw_reset_pulse === 1'b1) swr++;
    if (cyc == 6000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    checks_done++;
    if (g !== x) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00, q);
    chk(q, x);
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  initial begin
    do_reset();
    chk({7'h0, fifo_enable}, 8'h00);
    chk({6'h0, motor_b_on_n, motor_a_on_n}, 8'h03);
    drv.set_lines(1'b0, 1'b0);
    rd(6'h1C, 8'hF8);
    rd(6'h10, 8'h5A);
    wr(6'h08, 8'h35);
    drv.pulse(1'b1, 3);
    drv.pulse(1'b0, 2);
    rd(6'h04, 8'hF7);
    $display("status and input pins done");
    for (int r = 0; r < 4; r++) begin
      wr(6'h10, 8'(r));
      chk({6'h0, rate_sel}, 8'(r));
      chk({7'h0, reduced_write_current}, {7'h0, r == 0 || r == 3});
      rd(6'h1C, {5'h1F, 2'(r), r == 1 || r == 2});
      wr(6'h1C, 8'(3 - r));
      rd(6'h1C, {5'h1F, 2'(3 - r), r == 1 || r == 2});
    end
    for (int r = 0; r < 4; r++) begin
      for (int p = 0; p < 8; p++) begin
        wr(6'h10, {3'h0, 3'(p), 2'(r)});
        ps = (p == 0) ? ((r == 3) ? DEF_STEPS_1M : DEF_STEPS_LOW) : (p == 7) ? 3'h0 : 3'(p);
        chk({5'h0, select_a_steps}, {5'h0, ps});
      end
    end
    wr(6'h20, 8'h11);
    wr(6'h10, 8'h01);
    chk({6'h0, tape_rate_2m, select_a_half_step}, 8'h03);
    chk({5'h0, select_a_steps}, {5'h0, DEF_STEPS_1M});
    wr(6'h10, 8'h02);
    chk({7'h0, tape_rate_2m}, 8'h00);
    wr(6'h10, 8'hC0);
    repeat (3) @(posedge pclk);
    chk(8'(swr), 8'h01);
    chk({7'h0, power_down}, 8'h01);
    wr(6'h10, 8'h00);
    chk({7'h0, power_down}, 8'h00);
    $display("rate control done");
    wr(6'h20, 8'h01);
    for (int t = 0; t < 4; t++) begin
      wr(6'h0C, {6'h3F, 2'(t)});
      chk({6'h0, tape_drive}, 8'(t));
      rd(6'h0C, 8'(t));
    end
    wr(6'h24, 8'hE4);
    wr(6'h28, 8'h09);
    wr(6'h20, 8'h05);
    rd(6'h0C, 8'h97);
    wr(6'h08, 8'h36);
    rd(6'h0C, 8'hA7);
    $display("tape register done");
    wr(6'h20, 8'h02);
    wr(6'h08, 8'h0E);
    chk({7'h0, drive_c_selected_n}, 8'h00);
    rd(6'h04, 8'hD4);
    wr(6'h1C, 8'h05);
    rd(6'h1C, 8'h7D);
    wr(6'h20, 8'h00);
    rd(6'h1C, 8'h80);
    wr(6'h20, 8'h01);
    $display("modes done");
    wr(6'h14, CONFIGURE_CMD);
    chk(cmd_byte, CONFIGURE_CMD);
    chk({7'h0, cmd_strobe}, 8'h01);
    wr(6'h14, 8'h00);
    wr(6'h14, 8'h00);
    chk({7'h0, fifo_enable}, 8'h01);
    @(posedge pclk);
    result_load <= 1'b1;
    @(posedge pclk);
    result_load <= 1'b0;
    for (int i = 0; i < 5; i++) rd(6'h14, 8'((i % 4 + 1) * 17));
    apb(1'b0, 6'h00, 8'h00, q);
    chk({7'h0, e}, 8'h01);
    apb(1'b0, 6'h08, 8'h00, q);
    chk({7'h0, e}, 8'h01);
    $display("data and errors done");
    do_reset();
    #1;
    chk({drive_sel, transfer_request_enable, controller_reset, motor_b_on_n, motor_a_on_n, 2'h0}, 8'h1C);
    $display("second reset done");
    tally_and_finish();
  end
endmodule // fhr_regs_tb
